// file: rtl/pepda_top.sv
// PCI event pending, force and DMA burst address registers behind an APB slave
//
// Overview of operation
// - The pending register holds eight event bits from DMA done at bit 7 down to SERR seen at bit 0, upper bits zero.
// - Writing a one to a pending bit clears it and writing a zero leaves it alone.
// - Initiator internal fault sets on busy start, 1 KB boundary, PCI-area target, timeout or reset during DMA.
// - Initiator fatal fault sets on an initiator address parity error or an aborted transaction.
// - Initiator parity fault sets on initiator read or write data with a parity error.
// - Target internal fault sets when the target cannot complete, including a timeout.
// - Target byte-enable fault sets when the target receives an unsupported byte-enable pattern.
// - Target parity fault sets when the target receives data with a parity error.
// - Writing a one to a force bit sets the matching pending bit.
// - Writing a zero to force bits 7 to 1 clears the matching pending bit.
// - Reading the force register returns the pending register.
// - A write to the force register raises the interrupt at the time of the write.
// - Writing the DMA address while no burst runs and outside the PCI area loads the burst start address and with a nonzero word count starts the burst at once.
// - Reading the DMA address gives the current address in a burst or, after it, the address one word past the last word moved.
// - The DMA address steps by 4 per word and stops at the word count or the 1 KB segment end.
`timescale 1ns/1ns
`include "pepda_map.svh"

module pepda_top import pepda_pkg::*; (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PCI initiator events
  input wire logic init_addr_parity_err,
  input wire logic init_abort,
  input wire logic init_data_parity_err,
  input wire logic dma_timeout,
  input wire logic itf_reset,
  input wire logic dma_pci_area,
  // PCI target events
  input wire logic tgt_internal_err,
  input wire logic tgt_timeout,
  input wire logic tgt_be_err,
  input wire logic tgt_parity_err,
  input wire logic serr_seen,
  // DMA engine
  input wire logic dma_word_done,
  output logic [31:0] dma_addr,
  output logic dma_active,
  output logic [`PEPDA_CNT_W-1:0] dma_word_count,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  pepda_ev_t event_pending;
  pepda_ev_t event_enable;
  logic [`PEPDA_CNT_W-1:0] word_count;
  logic [31:0] rd_data;
  logic irq_q;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire full_word = (pstrb == 4'hf);

  wire hit_enable = pepda_hit(paddr, `PEPDA_OFF_ENABLE);
  wire hit_pending = pepda_hit(paddr, `PEPDA_OFF_PENDING);
  wire hit_force = pepda_hit(paddr, `PEPDA_OFF_FORCE);
  wire hit_count = pepda_hit(paddr, `PEPDA_OFF_COUNT);
  wire hit_addr = pepda_hit(paddr, `PEPDA_OFF_DMA_ADDR);
  wire hit_any = hit_enable || hit_pending || hit_force || hit_count || hit_addr;

  wire wr_ok = wr && hit_any;
  wire wr_low = wr_ok && pstrb[0];
  wire wr_enable = wr_low && hit_enable;
  wire wr_pending = wr_low && hit_pending;
  wire wr_force = wr_low && hit_force;
  wire wr_count = wr_ok && hit_count && pstrb[0] && pstrb[1];
  wire wr_addr = wr_ok && hit_addr && full_word;

  assign pready = 1'b1;
  assign pslverr = access && !hit_any;

  // ----------------------------------------
  // DMA start and burst control
  // ----------------------------------------
  wire dma_busy_start = wr_addr && dma_active;
  wire dma_area_start = wr_addr && !dma_active && dma_pci_area;
  wire dma_start = wr_addr && !dma_active && !dma_pci_area;
  wire dma_abort = dma_timeout || itf_reset;
  wire dma_done;
  wire dma_seg_end;

  pepda_burst #(
    .CW(`PEPDA_CNT_W)
  ) pepda_burst_i (
    .pclk(pclk),
    .presetn(presetn),
    .start(dma_start),
    .start_addr(pwdata),
    .word_count(word_count),
    .word_done(dma_word_done),
    .abort(dma_abort),
    .addr(dma_addr),
    .active(dma_active),
    .done(dma_done),
    .seg_end(dma_seg_end)
  );

  assign dma_word_count = word_count;

  // ----------------------------------------
  // Hardware event collection
  // ----------------------------------------
  wire init_internal = dma_busy_start || dma_seg_end || dma_area_start
    || (dma_timeout && dma_active) || (itf_reset && dma_active);
  wire init_fatal = init_addr_parity_err || init_abort;
  wire tgt_internal = tgt_internal_err || tgt_timeout;

  pepda_ev_t hw_set;

  always_comb begin
    hw_set = `PEPDA_RST_EVENTS;
    hw_set[`PEPDA_EV_DMA_DONE] = dma_done;
    hw_set[`PEPDA_EV_INIT_INTERNAL] = init_internal;
    hw_set[`PEPDA_EV_INIT_FATAL] = init_fatal;
    hw_set[`PEPDA_EV_INIT_PARITY] = init_data_parity_err;
    hw_set[`PEPDA_EV_TGT_INTERNAL] = tgt_internal;
    hw_set[`PEPDA_EV_TGT_BYTE_EN] = tgt_be_err;
    hw_set[`PEPDA_EV_TGT_PARITY] = tgt_parity_err;
    hw_set[`PEPDA_EV_SERR_SEEN] = serr_seen;
  end

  // ----------------------------------------
  // Software clear and force
  // ----------------------------------------
  wire [`PEPDA_EV_W-1:0] wdata_ev = pwdata[`PEPDA_EV_W-1:0];
  wire [`PEPDA_EV_W-1:0] w1c_mask = wr_pending ? wdata_ev : '0;
  wire [`PEPDA_EV_W-1:0] force_set = wr_force ? wdata_ev : '0;
  wire [`PEPDA_EV_W-1:0] force_zero_mask = {{(`PEPDA_EV_W-1){1'b1}}, 1'b0};
  wire [`PEPDA_EV_W-1:0] force_clr = wr_force ? (~wdata_ev & force_zero_mask) : '0;

  // Hardware set wins over any software clear in the same cycle
  wire [`PEPDA_EV_W-1:0] next_pending =
    ((event_pending & ~w1c_mask & ~force_clr) | force_set) | hw_set;

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  wire next_irq = (|(next_pending & event_enable)) || wr_force;

  assign irq = irq_q;

  // ----------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------
  wire [31:0] rd_enable = {{(32-`PEPDA_EV_W){1'b0}}, event_enable};
  wire [31:0] rd_pending = {{(32-`PEPDA_EV_W){1'b0}}, event_pending};
  wire [31:0] rd_count = {dma_active, {(31-`PEPDA_CNT_W){1'b0}}, word_count};

  wire [31:0] next_rd_data =
    hit_enable ? rd_enable :
    hit_pending ? rd_pending :
    hit_force ? rd_pending :
    hit_count ? rd_count :
    hit_addr ? dma_addr :
    32'h00000000;

  assign prdata = rd_data;

  // ----------------------------------------
  // State update
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_pending <= `PEPDA_RST_EVENTS;
      irq_q <= 1'b0;
    end else begin
      event_pending <= next_pending;
      irq_q <= next_irq;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_enable <= `PEPDA_RST_EVENTS;
      word_count <= `PEPDA_RST_COUNT;
    end else begin
      if (wr_enable) begin
        event_enable <= wdata_ev;
      end
      if (wr_count) begin
        word_count <= pwdata[`PEPDA_CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= 32'h00000000;
    end else if (setup && !pwrite) begin
      rd_data <= next_rd_data;
    end
  end

endmodule

// file: rtl/pepda_map.svh
// Register offsets, field positions and reset values of the event and DMA address block
`ifndef PEPDA_MAP_SVH
`define PEPDA_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PEPDA_OFF_ENABLE 32'h80000164
`define PEPDA_OFF_PENDING 32'h80000168
`define PEPDA_OFF_FORCE 32'h8000016c
`define PEPDA_OFF_COUNT 32'h80000174
`define PEPDA_OFF_DMA_ADDR 32'h80000178

// ----------------------------------------
// Event bit positions
// ----------------------------------------
`define PEPDA_EV_DMA_DONE 7
`define PEPDA_EV_INIT_INTERNAL 6
`define PEPDA_EV_INIT_FATAL 5
`define PEPDA_EV_INIT_PARITY 4
`define PEPDA_EV_TGT_INTERNAL 3
`define PEPDA_EV_TGT_BYTE_EN 2
`define PEPDA_EV_TGT_PARITY 1
`define PEPDA_EV_SERR_SEEN 0

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define PEPDA_EV_W 8
`define PEPDA_CNT_W 9
`define PEPDA_CNT_BUSY_BIT 31
`define PEPDA_SEG_LSB 2
`define PEPDA_SEG_MSB 9

// ----------------------------------------
// Reset values and steps
// ----------------------------------------
`define PEPDA_RST_EVENTS 8'h00
`define PEPDA_RST_ADDR 32'h00000000
`define PEPDA_RST_COUNT 9'h000
`define PEPDA_WORD_STEP 32'h00000004
`define PEPDA_SEG_LAST 8'hff

`endif

// file: rtl/pepda_pkg.sv
// Types and helper functions of the event and DMA address block
`include "pepda_map.svh"

package pepda_pkg;

  typedef logic [`PEPDA_EV_W-1:0] pepda_ev_t;

  typedef enum logic {
    pepda_st_idle = 1'b0,
    pepda_st_run = 1'b1
  } pepda_burst_st_t;

  function automatic logic pepda_hit(input logic [31:0] addr, input logic [31:0] off);
    pepda_hit = (addr[31:2] == off[31:2]);
  endfunction

  function automatic logic [31:0] pepda_word_inc(input logic [31:0] addr);
    pepda_word_inc = addr + `PEPDA_WORD_STEP;
  endfunction

endpackage

// file: rtl/pepda_burst.sv
// DMA burst address counter with word count and 1 KB segment stop
`timescale 1ns/1ns
`include "pepda_map.svh"

module pepda_burst import pepda_pkg::*; #(
  parameter int CW = `PEPDA_CNT_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic start,
  input wire logic [31:0] start_addr,
  input wire logic [CW-1:0] word_count,
  input wire logic word_done,
  input wire logic abort,
  // Status
  output logic [31:0] addr,
  output logic active,
  output logic done,
  output logic seg_end
);

  pepda_burst_st_t state;
  logic [CW-1:0] remaining;

  // ----------------------------------------
  // Stop conditions
  // ----------------------------------------
  wire running = (state == pepda_st_run);
  wire step = running && word_done;
  wire last_word = step && (remaining == CW'(1));
  wire seg_last = step && (addr[`PEPDA_SEG_MSB:`PEPDA_SEG_LSB] == `PEPDA_SEG_LAST);
  wire finish = last_word || seg_last;
  wire empty_start = start && (word_count == '0);

  assign active = running;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= pepda_st_idle;
      addr <= `PEPDA_RST_ADDR;
      remaining <= '0;
      done <= 1'b0;
      seg_end <= 1'b0;
    end else begin
      done <= 1'b0;
      seg_end <= 1'b0;
      case (state)
        pepda_st_idle: begin
          if (start) begin
            addr <= start_addr;
            remaining <= word_count;
            state <= empty_start ? pepda_st_idle : pepda_st_run;
            done <= empty_start;
          end
        end
        pepda_st_run: begin
          if (abort) begin
            state <= pepda_st_idle;
          end else if (step) begin
            addr <= pepda_word_inc(addr);
            remaining <= remaining - CW'(1);
            if (finish) begin
              state <= pepda_st_idle;
              done <= 1'b1;
              seg_end <= seg_last && !last_word;
            end
          end
        end
        default: state <= pepda_st_idle;
      endcase
    end
  end

endmodule

// file: dv/pepda_far_model.sv
// Far-side model: PCI event sources and DMA word mover
`timescale 1ns/1ns
module pepda_far_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench requests
  input wire logic [9:0] ev_req,
  input wire logic [3:0] words,
  input wire logic slow,
  // Block side
  input wire logic dma_active,
  output logic [9:0] ev,
  output logic dma_word_done
);
  logic [3:0] left;
  logic gap;
  wire mv = dma_active && left != 4'h0 && (!slow || gap);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev <= 10'h000;
      dma_word_done <= 1'b0;
      left <= 4'h0;
      gap <= 1'b0;
    end else begin
      ev <= ev_req;
      gap <= !gap;
      dma_word_done <= mv;
      if (words != 4'h0) left <= words;
      else if (mv) left <= left - 4'h1;
    end
  end
endmodule

// file: dv/pepda_assertions.sv
// Port checks of the event and DMA address block
`timescale 1ns/1ns
`include "pepda_map.svh"
module pepda_assertions import pepda_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // Far side
  input wire logic dma_timeout,
  input wire logic itf_reset,
  input wire logic dma_pci_area,
  input wire logic dma_word_done,
  input wire logic [31:0] dma_addr,
  input wire logic dma_active,
  input wire logic [`PEPDA_CNT_W-1:0] dma_word_count,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pwrite;
  wire dwr = acc && paddr == `PEPDA_OFF_DMA_ADDR && pstrb == 4'hf;
  wire fwr = acc && paddr == `PEPDA_OFF_FORCE && pstrb[0];
  wire mv = dma_active && dma_word_done;
  a_force_irq:
    assert property (fwr |=> irq) else $error("no irq on force");
  a_dma_load:
    assert property (dwr && !dma_active && !dma_pci_area && dma_word_count != 9'h000
      |=> dma_active && dma_addr == $past(pwdata)) else $error("burst not started");
  a_dma_step:
    assert property (mv && !dma_timeout && !itf_reset && dma_addr[9:2] != 8'hff
      |=> dma_addr == $past(dma_addr) + 32'h4) else $error("bad address step");
  a_addr_hold:
    assert property (!dma_active && !dwr |=> $stable(dma_addr)) else $error("idle addr moved");
  a_busy_keep:
    assert property (dwr && dma_active && !dma_word_done |=> $stable(dma_addr))
      else $error("busy write took");
  a_tmo_abort:
    assert property (dma_active && dma_timeout |=> !dma_active) else $error("no abort");
  a_seg_stop:
    assert property (mv && dma_addr[9:2] == 8'hff |=> !dma_active) else $error("no seg stop");
  a_pci_refuse:
    assert property (dwr && !dma_active && dma_pci_area |=> !dma_active)
      else $error("pci area started");
  cover property (fwr);
  cover property (mv);
  cover property (dwr && dma_active);
endmodule
bind pepda_top pepda_assertions pepda_assertions_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .dma_timeout(dma_timeout), .itf_reset(itf_reset),
  .dma_pci_area(dma_pci_area), .dma_word_done(dma_word_done), .dma_addr(dma_addr),
  .dma_active(dma_active), .dma_word_count(dma_word_count), .irq(irq));

// file: dv/pepda_top_tb_top.sv
// Testbench of the event and DMA address block
`timescale 1ns/1ns
`include "pepda_map.svh"
module pepda_top_tb_top import pepda_pkg::*;;
  localparam logic [31:0] pd = `PEPDA_OFF_PENDING;
  localparam logic [31:0] fc = `PEPDA_OFF_FORCE;
  localparam logic [31:0] da = `PEPDA_OFF_DMA_ADDR;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [31:0] paddr = 0, pwdata = 0, prdata, dma_addr;
  logic [3:0] pstrb = 4'hf, words = 0;
  logic [9:0] ev_req = 0, ev;
  logic slow = 0, dma_pci_area = 0, dma_word_done, dma_active, irq;
  logic [8:0] dma_word_count;
  int bad_count = 0, n_tests = 0;
  int bp[10] = '{0, 1, 2, 3, 3, 6, 6, 4, 5, 5};
  initial forever #2 pclk = ~pclk;
  pepda_top pepda_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serr_seen(ev[0]), .tgt_parity_err(ev[1]),
    .tgt_be_err(ev[2]), .tgt_timeout(ev[3]), .tgt_internal_err(ev[4]), .itf_reset(ev[5]),
    .dma_timeout(ev[6]), .init_data_parity_err(ev[7]), .init_abort(ev[8]),
    .init_addr_parity_err(ev[9]), .dma_pci_area(dma_pci_area), .irq(irq),
    .dma_word_done(dma_word_done), .dma_addr(dma_addr), .dma_active(dma_active),
    .dma_word_count(dma_word_count));
  pepda_far_model pepda_far_model_i (.pclk(pclk), .presetn(presetn), .ev_req(ev_req),
    .words(words), .slow(slow), .dma_active(dma_active), .ev(ev),
    .dma_word_done(dma_word_done));
  task stop_test;
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, d, output logic [31:0] r, output logic e);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      k++;
      if (k > 50) begin
        bad_count++;
        stop_test;
      end
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [31:0] a, d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rd(input string nm, input logic [31:0] a, x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, x);
    chk("pslverr", {31'h0, e}, {31'h0, xe});
  endtask
  task pulse(input int i);
    ev_req <= 10'h1 << i;
    @(posedge pclk);
    ev_req <= 10'h0;
    repeat (2) @(posedge pclk);
  endtask
  task ck_irq(input logic x);
    @(negedge pclk);
    chk("irq", {31'h0, irq}, {31'h0, x});
    @(posedge pclk);
  endtask
  task dma(input logic [31:0] cnt, a, input logic [3:0] n);
    words <= n;
    @(posedge pclk);
    words <= 4'h0;
    wr(`PEPDA_OFF_COUNT, cnt);
    wr(da, a);
  endtask
  task idle;
    int k;
    for (k = 0; k < 100 && dma_active !== 1'b0; k++) @(posedge pclk);
    if (k == 100) begin
      bad_count++;
      stop_test;
    end
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("pending", pd, 32'h0, 1'b0);
    rd("force", fc, 32'h0, 1'b0);
    rd("unmapped", 32'h80000000, 32'h0, 1'b1);
    for (int i = 0; i < 10; i++) if (i != 5 && i != 6) begin
      pulse(i);
      wr(pd, ~(32'h1 << bp[i]));
      rd("event", pd, 32'h1 << bp[i], 1'b0);
      wr(pd, 32'h1 << bp[i]);
      rd("cleared", pd, 32'h0, 1'b0);
    end
    wr(fc, 32'hff);
    rd("force", fc, 32'hff, 1'b0);
    wr(fc, 32'h0);
    rd("forced zero", pd, 32'h1, 1'b0);
    wr(`PEPDA_OFF_ENABLE, 32'h1);
    ck_irq(1'b1);
    wr(pd, 32'hff);
    ck_irq(1'b0);
    dma(32'h3, 32'h1000, 4'h3);
    idle;
    rd("dma addr", da, 32'h100c, 1'b0);
    rd("done", pd, 32'h80, 1'b0);
    wr(pd, 32'hff);
    slow <= 1'b1;
    dma(32'h8, 32'h13f8, 4'h8);
    idle;
    rd("seg end", pd, 32'hc0, 1'b0);
    wr(pd, 32'hff);
    dma(32'h8, 32'h2000, 4'h8);
    wr(da, 32'h3000);
    idle;
    rd("busy burst", da, 32'h2020, 1'b0);
    rd("busy start", pd, 32'hc0, 1'b0);
    for (int i = 5; i < 7; i++) begin
      wr(pd, 32'hff);
      dma(32'h8, 32'h2000, 4'h0);
      pulse(i);
      rd("abort", pd, 32'h40, 1'b0);
    end
    wr(pd, 32'hff);
    dma_pci_area <= 1'b1;
    dma(32'h8, 32'h2000, 4'h0);
    dma_pci_area <= 1'b0;
    rd("pci area", pd, 32'h40, 1'b0);
    chk("active", {31'h0, dma_active}, 32'h0);
    rd("count", `PEPDA_OFF_COUNT, 32'h8, 1'b0);
    chk("word count", {23'h0, dma_word_count}, 32'h8);
    rd("enable", `PEPDA_OFF_ENABLE, 32'h1, 1'b0);
    pstrb <= 4'h7;
    wr(da, 32'h4000);
    pstrb <= 4'hf;
    chk("part write", {31'h0, dma_active}, 32'h0);
    rd("part addr", da, 32'h2000, 1'b0);
    stop_test;
  end
endmodule
